// file: pcn_pkg.sv
// Package of constants and types for the port change notification block
package pcn_pkg;
   localparam int NUM_PORTS  = 3;
   localparam int PORT_WIDTH = 16;
   localparam int ADDR_WIDTH = 12;
   localparam int DATA_WIDTH = 32;

   // Register layout: one 0x40 window per port
   localparam logic [11:0] PORT_STRIDE      = 12'h040;
   localparam logic [5:0]  OFS_CONTROL      = 6'h00;
   localparam logic [5:0]  OFS_PORT_VALUE   = 6'h10;
   localparam logic [5:0]  OFS_MISMATCH     = 6'h20;
   localparam logic [5:0]  OFS_EDGE_FLAGS   = 6'h30;
   localparam logic [3:0]  ALIAS_WRITE      = 4'h0;
   localparam logic [3:0]  ALIAS_CLEAR      = 4'h4;
   localparam logic [3:0]  ALIAS_SET        = 4'h8;
   localparam logic [3:0]  ALIAS_INVERT     = 4'hC;
   localparam logic [11:0] OFS_IRQ_STATUS   = 12'h100;
   localparam logic [11:0] OFS_IRQ_MASK     = 12'h110;

   // Address fields: page, port select, register, alias
   localparam int         ADDR_SEL_LSB    = 6;
   localparam int         ADDR_SEL_BITS   = 2;
   localparam int         ADDR_REG_LSB    = 4;
   localparam int         ADDR_REG_BITS   = 2;
   localparam int         ADDR_ALIAS_BITS = 4;
   localparam int         ADDR_PAGE_LSB   = 8;
   localparam int         ADDR_PAGE_BITS  = 4;
   localparam logic [3:0] PAGE_PORTS      = 4'h0;

   localparam int BIT_ENABLE = 15;
   localparam int BIT_STYLE  = 11;
   localparam logic [31:0] CONTROL_MASK  = 32'h0000_8800;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

   // One sampled pin group per port
   typedef struct packed {
      logic [PORT_WIDTH-1:0] level;
   } pcn_pins_type;
endpackage

// file: pcn_detect.sv
// Per-port change detector: edge flags and mismatch status
`timescale 1ns/100ps
module pcn_detect #(
   parameter int WIDTH = 16
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset,
   // Control
   input  wire logic             enable,
   input  wire logic             edgeStyle,
   input  wire logic             portRead,
   // Pin levels, already synchronised
   input  wire logic [WIDTH-1:0] pinLevel,
   // Software alias writes to flag or status
   input  wire logic [WIDTH-1:0] flagNxtSw,
   input  wire logic             flagWr,
   input  wire logic [WIDTH-1:0] statNxtSw,
   input  wire logic             statWr,
   // State
   output logic      [WIDTH-1:0] edgeFlags_r,
   output logic      [WIDTH-1:0] mismatch_r,
   output logic                  event_r
);
   logic [WIDTH-1:0] prev_r;
   logic [WIDTH-1:0] readSnap_r;
   logic [WIDTH-1:0] edgeHit;
   logic [WIDTH-1:0] mismHit;
   logic [WIDTH-1:0] flagBase;
   logic [WIDTH-1:0] statBase;

   assign edgeHit  = (enable && edgeStyle) ? (pinLevel ^ prev_r) : '0;
   assign mismHit  = (enable && !edgeStyle) ? (pinLevel ^ readSnap_r) : '0;
   assign flagBase = flagWr ? flagNxtSw : edgeFlags_r;
   assign statBase = statWr ? statNxtSw : mismatch_r;

   always_ff @(posedge core_clk)
   begin
      if (reset)
         prev_r <= '0;
      else
         prev_r <= pinLevel;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         readSnap_r <= '0;
      else if (portRead)
         readSnap_r <= pinLevel;
   end

   // Hardware set wins over software clear
   always_ff @(posedge core_clk)
   begin
      if (reset)
         edgeFlags_r <= '0;
      else
         edgeFlags_r <= flagBase | edgeHit;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         mismatch_r <= '0;
      else
         mismatch_r <= statBase | mismHit;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         event_r <= 1'b0;
      else
         event_r <= |(edgeHit | mismHit);
   end
endmodule

// file: pcn_top.sv
// Change notification control for ports A to C with register port
//
// Operation
// - Bit 15 enables port change detection
// - Style one: edges set per-pin edge flags
// - Style zero: mismatch against last read
// - Other control bits read as zero
// - Separate identical control register per port
// - Clear, set, invert aliases at 4, 8, C
`timescale 1ns/100ps
module pcn_top #(
   parameter int PORTS = pcn_pkg::NUM_PORTS,
   parameter int WIDTH = pcn_pkg::PORT_WIDTH
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // Register port
   input  wire logic [11:0] regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdData,
   // Port pins, asynchronous
   input  wire logic [PORTS*WIDTH-1:0] pinIn,
   // Interrupt
   output logic             irq
);
   ////////////////////////////////////////////////////////////////////////
   // Address decode
   logic [1:0]  portSel;
   logic [5:0]  regOfs;
   logic [3:0]  aliasOfs;
   logic        inPorts;
   logic        plainAcc;

   assign portSel  = regAddr[pcn_pkg::ADDR_SEL_LSB +: pcn_pkg::ADDR_SEL_BITS];
   assign regOfs   = {regAddr[pcn_pkg::ADDR_REG_LSB +: pcn_pkg::ADDR_REG_BITS], pcn_pkg::ALIAS_WRITE};
   assign aliasOfs = regAddr[pcn_pkg::ADDR_ALIAS_BITS-1:0];
   assign inPorts  = (regAddr[pcn_pkg::ADDR_PAGE_LSB +: pcn_pkg::ADDR_PAGE_BITS] == pcn_pkg::PAGE_PORTS)
                     && (32'(portSel) < PORTS);
   assign plainAcc = aliasOfs == pcn_pkg::ALIAS_WRITE;

   // Alias arithmetic on a register value
   function automatic logic [31:0] aliasApply(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [3:0] al);
      logic [31:0] res;
      res = cur;
      unique case (al)
         pcn_pkg::ALIAS_WRITE:  res = wd;
         pcn_pkg::ALIAS_CLEAR:  res = cur & ~wd;
         pcn_pkg::ALIAS_SET:    res = cur | wd;
         pcn_pkg::ALIAS_INVERT: res = cur ^ wd;
         default:               res = cur;
      endcase
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [PORTS*WIDTH-1:0] pinMeta_r;
   logic [PORTS*WIDTH-1:0] pinSync_r;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
      end
      else
      begin
         pinMeta_r <= pinIn;
         pinSync_r <= pinMeta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-port control and detectors
   logic [31:0]      control_r [PORTS];
   logic [WIDTH-1:0] edgeFlags [PORTS];
   logic [WIDTH-1:0] mismatch  [PORTS];
   logic [PORTS-1:0] portEvent;

   genvar gp;
   generate
      for (gp = 0; gp < PORTS; gp++)
      begin : g_port
         logic                  hit;
         logic                  rdValue;
         logic [31:0]           flagNew;
         logic [31:0]           statNew;
         logic [31:0]           control_nxt;
         pcn_pkg::pcn_pins_type pins;

         assign pins.level = pinSync_r[gp*WIDTH +: WIDTH];
         assign hit     = regWrite && inPorts && (32'(portSel) == gp);
         // Only a plain read of the value register moves the reference
         assign rdValue = regRead && inPorts && (32'(portSel) == gp)
                          && regOfs == pcn_pkg::OFS_PORT_VALUE && plainAcc;
         assign flagNew = aliasApply({16'h0000, edgeFlags[gp]}, regWrData, aliasOfs);
         assign statNew = aliasApply({16'h0000, mismatch[gp]}, regWrData, aliasOfs);

         always_comb
         begin
            control_nxt = control_r[gp];
            if (hit && regOfs == pcn_pkg::OFS_CONTROL)
               control_nxt = aliasApply(control_r[gp], regWrData, aliasOfs)
                             & pcn_pkg::CONTROL_MASK;
         end

         always_ff @(posedge core_clk)
         begin
            if (reset)
               control_r[gp] <= pcn_pkg::CONTROL_RESET;
            else
               control_r[gp] <= control_nxt;
         end

         pcn_detect #(.WIDTH(WIDTH)) u_detect (
            .core_clk    (core_clk),
            .reset       (reset),
            .enable      (control_r[gp][pcn_pkg::BIT_ENABLE]),
            .edgeStyle   (control_r[gp][pcn_pkg::BIT_STYLE]),
            .portRead    (rdValue),
            .pinLevel    (pins.level),
            .flagNxtSw   (flagNew[WIDTH-1:0]),
            .flagWr      (hit && regOfs == pcn_pkg::OFS_EDGE_FLAGS),
            .statNxtSw   (statNew[WIDTH-1:0]),
            .statWr      (hit && regOfs == pcn_pkg::OFS_MISMATCH),
            .edgeFlags_r (edgeFlags[gp]),
            .mismatch_r  (mismatch[gp]),
            .event_r     (portEvent[gp])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask
   localparam logic [31:0] PORT_BITS = 32'((64'h1 << PORTS) - 64'h1);

   logic [31:0] irqStatus_r;
   logic [31:0] irqMask_r;
   logic [31:0] irqStatus_nxt;
   logic [31:0] irqMask_nxt;
   logic        statusRead;
   logic        maskWrite;

   assign statusRead = regRead && regAddr == pcn_pkg::OFS_IRQ_STATUS;
   assign maskWrite  = regWrite && regAddr == pcn_pkg::OFS_IRQ_MASK;

   // Read clears; a new event in the same cycle survives
   always_comb
   begin
      irqStatus_nxt = irqStatus_r;
      if (statusRead)
         irqStatus_nxt = 32'h0000_0000;
      irqStatus_nxt = irqStatus_nxt | 32'(portEvent);
   end

   always_comb
   begin
      irqMask_nxt = irqMask_r;
      if (maskWrite)
         irqMask_nxt = regWrData & PORT_BITS;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         irqStatus_r <= '0;
      else
         irqStatus_r <= irqStatus_nxt;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         irqMask_r <= '0;
      else
         irqMask_r <= irqMask_nxt;
   end

   // Level output follows the status and mask registers
   always_ff @(posedge core_clk)
   begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(irqStatus_nxt & irqMask_nxt);
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path, data one cycle after the strobe
   logic [31:0]      rdMux;
   logic [31:0]      selControl;
   logic [WIDTH-1:0] selValue;
   logic [WIDTH-1:0] selMism;
   logic [WIDTH-1:0] selFlags;

   // Unused port index selects nothing
   always_comb
   begin
      selControl = 32'h0000_0000;
      selValue   = '0;
      selMism    = '0;
      selFlags   = '0;
      for (int p = 0; p < PORTS; p++)
      begin
         if (32'(portSel) == p)
         begin
            selControl = control_r[p];
            selValue   = pinSync_r[p*WIDTH +: WIDTH];
            selMism    = mismatch[p];
            selFlags   = edgeFlags[p];
         end
      end
   end

   always_comb
   begin
      rdMux = 32'h0000_0000;
      if (regAddr == pcn_pkg::OFS_IRQ_STATUS)
         rdMux = irqStatus_r;
      else if (regAddr == pcn_pkg::OFS_IRQ_MASK)
         rdMux = irqMask_r;
      else if (inPorts && plainAcc)
      begin
         unique case (regOfs)
            pcn_pkg::OFS_CONTROL:    rdMux = selControl;
            pcn_pkg::OFS_PORT_VALUE: rdMux = 32'(selValue);
            pcn_pkg::OFS_MISMATCH:   rdMux = 32'(selMism);
            pcn_pkg::OFS_EDGE_FLAGS: rdMux = 32'(selFlags);
            default:                 rdMux = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         regRdData <= '0;
      else if (regRead)
         regRdData <= rdMux;
      else
         regRdData <= '0;
   end
endmodule

// file: pcn_checker.sv
// Register port checker for the change notification block
`timescale 1ns/100ps
module pcn_checker (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // Register port
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [31:0] regRdData
);
   localparam logic [31:0] MSK = pcn_pkg::CONTROL_MASK;
   logic base;
   logic ctl;
   // Control word of port A to C, any alias
   assign base = regAddr[11:8] == 4'h0 && regAddr[7:6] != 2'h3 && regAddr[5:4] == 2'h0;
   assign ctl  = base && regAddr[3:0] == 4'h0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   ctrl_mask_a:
      assert property (regRead && ctl |=> (regRdData & ~MSK) == 32'h0) else $error("ctrl spare bits");
   ctrl_keep_a:
      assert property (regWrite && ctl ##1 regRead && $stable(regAddr) |=> regRdData == ($past(regWrData, 2) & MSK))
      else $error("ctrl write lost");
   set_alias_a:
      assert property (regWrite && base && regAddr[3:0] == 4'h8 ##1 regRead && regAddr == ($past(regAddr) & 12'hFF0)
         |=> (regRdData & $past(regWrData, 2) & MSK) == ($past(regWrData, 2) & MSK)) else $error("set alias");
   clr_alias_a:
      assert property (regWrite && base && regAddr[3:0] == 4'h4 ##1 regRead && regAddr == ($past(regAddr) & 12'hFF0)
         |=> (regRdData & $past(regWrData, 2) & MSK) == 32'h0) else $error("clear alias");
   alias_read_a:
      assert property (regRead && regAddr[11:8] == 4'h0 && regAddr[3:0] != 4'h0 |=> regRdData == 32'h0)
      else $error("alias read");
   pin_high_a:
      assert property (regRead && regAddr[11:8] == 4'h0 && regAddr[7:6] != 2'h3 && regAddr[5:4] != 2'h0
         |=> regRdData[31:16] == 16'h0) else $error("pin reg high half");
   no_port_a:
      assert property (regRead && regAddr[11:6] == 6'h03 |=> regRdData == 32'h0) else $error("unmapped read");
   read_idle_a:
      assert property (!regRead |=> regRdData == 32'h0) else $error("idle read data");
endmodule
bind pcn_top pcn_checker chk (.core_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);

// file: pcn_pin_model.sv
// Behavioural model of the port pins
`timescale 1ns/100ps
module pcn_pin_model (
   // Clock
   input wire logic   core_clk,
   // Pin levels
   output logic [47:0] pinIn
);
   initial pinIn = 48'h0;
   task automatic toggle(input int n);
      @(posedge core_clk);
      pinIn[n] <= ~pinIn[n];
   endtask
endmodule

// file: tb_top.sv
// Self-checking testbench of the change notification block
`timescale 1ns/100ps
module tb_top;
   logic        core_clk;
   logic        reset;
   logic [11:0] regAddr;
   logic [31:0] regWrData;
   logic        regWrite;
   logic        regRead;
   logic [31:0] regRdData;
   logic [47:0] pinIn;
   logic        irq;
   int          err_total = 0;
   int          compares = 0;
   always #50 core_clk = ~core_clk;
   pcn_top dut (.core_clk, .reset, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .pinIn, .irq);
   pcn_pin_model pins (.core_clk, .pinIn);
   ////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge core_clk);
      regAddr   <= a;
      regWrData <= v;
      regWrite  <= 1'b1;
      @(posedge core_clk);
      regWrite  <= 1'b0;
   endtask
   // Read starts at the current edge, ends on the next one
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 chk($sformatf("reg %h", a), e, regRdData);
      @(posedge core_clk);
   endtask
   task automatic settle;
      repeat (6) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs;
      for (int p = 0; p < 3; p++)
      begin
         rdchk(12'(p * 64), 32'h0);
         wr(12'(p * 64), 32'hFFFF_FFFF);
         rdchk(12'(p * 64), 32'h0000_8800);
         rdchk(12'((p + 1) % 3 * 64), (p == 2) ? 32'h0000_8800 : 32'h0);
      end
      wr(12'h004, 32'h0000_8000);
      rdchk(12'h000, 32'h0000_0800);
      wr(12'h00C, 32'h0000_8800);
      rdchk(12'h000, 32'h0000_8000);
      wr(12'h008, 32'h0000_0800);
      rdchk(12'h000, 32'h0000_8800);
      rdchk(12'h008, 32'h0);
      rdchk(12'h0C0, 32'h0);
   endtask
   task automatic t_edge;
      wr(12'h110, 32'h1);
      pins.toggle(3);
      settle;
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(12'h030, 32'h0000_0008);
      rdchk(12'h100, 32'h1);
      settle;
      chk("irq", 32'h0, {31'h0, irq});
      wr(12'h110, 32'h0);
      wr(12'h034, 32'h0000_FFFF);
      pins.toggle(3);
      settle;
      rdchk(12'h030, 32'h0000_0008);
      chk("irq", 32'h0, {31'h0, irq});
      rdchk(12'h100, 32'h1);
   endtask
   task automatic t_mis;
      wr(12'h040, 32'h0000_8000);
      rdchk(12'h050, 32'h0);
      pins.toggle(16);
      settle;
      rdchk(12'h060, 32'h1);
      rdchk(12'h070, 32'h0);
      rdchk(12'h050, 32'h1);
      wr(12'h064, 32'h0000_FFFF);
      settle;
      rdchk(12'h060, 32'h0);
   endtask
   task automatic t_off;
      wr(12'h080, 32'h0);
      pins.toggle(37);
      settle;
      rdchk(12'h0B0, 32'h0);
      wr(12'h080, 32'h0000_8800);
      pins.toggle(37);
      settle;
      rdchk(12'h0B0, 32'h0000_0020);
      wr(12'h080, 32'h0);
      pins.toggle(37);
      settle;
      rdchk(12'h0B0, 32'h0000_0020);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("mismatches %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (4000) @(posedge core_clk);
      err_total++;
      report_and_stop;
   end
   initial
   begin
      core_clk  = 1'b0;
      reset     = 1'b1;
      regAddr   = 12'h000;
      regWrData = 32'h0000_0000;
      regWrite  = 1'b0;
      regRead   = 1'b0;
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      t_regs;
      t_edge;
      t_mis;
      t_off;
      report_and_stop;
   end
endmodule
